/* File: core/uar_defines.vh */
// Constants shared by the asynchronous receive recovery block
`ifndef UAR_DEFINES_VH
`define UAR_DEFINES_VH
`define UAR_SPB_NORMAL      5'h10
`define UAR_SPB_DOUBLE      5'h08
`define UAR_VOTE_FIRST_N    5'h08
`define UAR_VOTE_FIRST_D    5'h04
`define UAR_MIN_BITS        4'h5
`define UAR_MAX_BITS        4'hA
`define UAR_FIFO_WIDTH      11
`define UAR_FIFO_DEPTH      16
`define UAR_FIFO_AW         4
`endif

/* File: core/uar_fifo.v */
// Parameterised synchronous FIFO with valid/ready on both sides
module uar_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clock_in,     // System clock
    input  wire             reset_n_in,   // Synchronised reset, active low
    input  wire             flush_in,     // Empty the buffer
    input  wire             wr_valid_in,  // Write request
    output wire             wr_ready_out, // Space available
    input  wire [WIDTH-1:0] wr_data_in,   // Write word
    output wire             rd_valid_out, // Word available
    input  wire             rd_ready_in,  // Reader takes word
    output wire [WIDTH-1:0] rd_data_out   // Head word
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            do_wr;
    wire            do_rd;

    // Full and empty straight from the occupancy count
    assign wr_ready_out = (count_reg != DEPTH[AW:0]);
    assign rd_valid_out = (count_reg != {(AW+1){1'b0}});
    assign rd_data_out  = mem_reg[rd_ptr_reg];
    assign do_wr        = wr_valid_in & wr_ready_out;
    assign do_rd        = rd_valid_out & rd_ready_in;

    ////////////////////////////////////////////////////////////////////////////
    // Storage array, no reset needed
    always @(posedge clock_in)
    begin
        if (do_wr)
        begin
            mem_reg[wr_ptr_reg] <= wr_data_in;
        end
    end

    // Pointers and count; flush wins over traffic
    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end
        else if (flush_in)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (do_rd && !do_wr)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // uar_fifo

/* File: core/uar_rx.v */
// Asynchronous serial receive front end: start detect, bit voting, frame error
// Function
// - The line is sampled 16 times per bit normally and 8 times in double speed.
// - A low sample after idle high starts start-bit checking and counts as sample one.
// - Start validation votes samples 8,9,10 normally or 4,5,6 in double speed.
// - Two or more high validation samples reject the start as noise and idle resumes.
// - An accepted start aligns bit timing and begins data recovery, for every frame.
// - Recovery steps 16 (or 8) sample states per bit, sample index equal to state.
// - Each bit is the majority of its three centre samples.
// - Data and parity bits and the first stop bit are recovered; later stops ignored.
// - The first stop bit is voted and a zero sets the frame error flag.
// - A new falling edge is accepted right after the last stop voting sample.
// - Frames of five to ten data-plus-parity bits are handled.
// - The frame error travels in the buffer with the frame it describes.
// - Clearing the receiver enable stops reception at once and releases the pin.
//
// Timing
// Sample one is the first tick that sees the synchronised line low after a high tick.
// A bit lasts 16 ticks (8 in double speed); its vote ticks are 8-10 (4-6).
// The synchronised line lags the pin by two clocks, a fixed offset.
// Mode and length are taken at sample one, so changes apply to the next frame.
// A frame shows on the output two clocks after its stop vote.
// A frame that meets a full buffer is dropped and overrun pulses for one clock.
// A rejected start needs the line high again before another start counts.
// Buffer words carry the received bits with the stop-bit error in bit 10.
`include "uar_defines.vh"
module uar_rx (
    input  wire        clock_in,                // 100 MHz system clock
    input  wire        reset_n_in,              // Asynchronous reset, active low
    input  wire        serial_rx_in,            // Serial line pin
    input  wire        sample_tick_in,          // Sample-rate tick from baud generator
    input  wire        double_speed_select_in,  // 1 = 8 samples per bit
    input  wire        receiver_enable_bit_in,  // Receiver enable
    input  wire [3:0]  frame_bits_in,           // Data plus parity bits, 5..10
    input  wire        rd_ready_in,             // Consumer takes head frame
    output reg         rd_valid_out,            // Frame available
    output reg  [9:0]  rd_data_out,             // Received bits, first bit in bit 0
    output reg         frame_error_flag_out,    // Stop-bit error of head frame
    output reg         rx_pin_override_out,     // Receiver owns the pin
    output reg         overrun_out,             // Frame dropped, buffer full (pulse)
    output reg         busy_out                 // Frame in recovery
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_START = 3'b010;
    localparam ST_DATA  = 3'b100;

    // Reset and pin synchronisers
    reg        rst_meta_reg;
    reg        rst_sync_reg;
    reg        rx_meta_reg;
    reg        rx_sync_reg;
    reg        rx_prev_reg;
    // Frame recovery state
    reg [2:0]  state_reg;
    reg [4:0]  sample_reg;
    reg [3:0]  bit_idx_reg;
    reg [1:0]  votes_reg;
    reg [9:0]  shift_reg;
    // Buffer write port and per-frame settings
    reg        wr_valid_reg;
    reg [10:0] wr_data_reg;
    reg        flush_reg;
    reg        mode_reg;
    reg [3:0]  nbits_reg;

    // Decoded timing and buffer hand-off
    wire [4:0]  spb;
    wire [4:0]  vfirst;
    wire [3:0]  nbits_clamp;
    wire        vote_win;
    wire        last_vote;
    wire        voted;
    wire        fifo_ready;
    wire        fifo_valid;
    wire [10:0] fifo_data;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Pin synchroniser; idle level is high so reset to 1 avoids a false start
    always @(posedge clock_in or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end
        else
        begin
            rx_meta_reg <= serial_rx_in;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode; mode and length are latched per frame so a change mid-frame is harmless
    assign spb    = mode_reg ? `UAR_SPB_DOUBLE : `UAR_SPB_NORMAL;
    assign vfirst = mode_reg ? `UAR_VOTE_FIRST_D : `UAR_VOTE_FIRST_N;
    // Out-of-range lengths are clamped into 5..10
    assign nbits_clamp = (frame_bits_in < `UAR_MIN_BITS) ? `UAR_MIN_BITS :
                         (frame_bits_in > `UAR_MAX_BITS) ? `UAR_MAX_BITS :
                         frame_bits_in;
    // Centre samples are vfirst, vfirst+1, vfirst+2
    assign vote_win  = (sample_reg >= vfirst) && (sample_reg <= vfirst + 5'h02);
    assign last_vote = (sample_reg == vfirst + 5'h02);
    // Majority of three: two prior highs, or one prior plus this one
    assign voted = (votes_reg == 2'h2) || (votes_reg == 2'h1 && rx_sync_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Recovery state machine, advancing only on sample ticks
    always @(posedge clock_in or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            state_reg    <= ST_IDLE;
            sample_reg   <= 5'h00;
            bit_idx_reg  <= 4'h0;
            votes_reg    <= 2'h0;
            shift_reg    <= 10'h000;
            rx_prev_reg  <= 1'b1;
            wr_valid_reg <= 1'b0;
            wr_data_reg  <= 11'h000;
            mode_reg     <= 1'b0;
            nbits_reg    <= `UAR_MIN_BITS;
            busy_out     <= 1'b0;
            overrun_out  <= 1'b0;
        end
        else
        begin
            wr_valid_reg <= 1'b0;
            overrun_out  <= 1'b0;
            if (!receiver_enable_bit_in)
            begin
                state_reg   <= ST_IDLE;
                sample_reg  <= 5'h00;
                votes_reg   <= 2'h0;
                rx_prev_reg <= 1'b1;
                busy_out    <= 1'b0;
            end
            else if (sample_tick_in)
            begin
                rx_prev_reg <= rx_sync_reg;
                case (state_reg)
                    ST_IDLE:
                    begin
                        // Falling edge: this low sample is sample one
                        if (rx_prev_reg && !rx_sync_reg)
                        begin
                            state_reg  <= ST_START;
                            sample_reg <= 5'h02;
                            votes_reg  <= 2'h0;
                            mode_reg   <= double_speed_select_in;
                            nbits_reg  <= nbits_clamp;
                            busy_out   <= 1'b1;
                        end
                        else
                        begin
                            // Keep the sample state parked until a start arrives
                            sample_reg <= 5'h00;
                            votes_reg  <= 2'h0;
                        end
                    end
                    ST_START:
                    begin
                        sample_reg <= sample_reg + 5'h01;
                        // Count highs inside the vote window
                        if (vote_win && rx_sync_reg)
                        begin
                            votes_reg <= votes_reg + 2'h1;
                        end
                        if (last_vote)
                        begin
                            if (voted)
                            begin
                                state_reg   <= ST_IDLE;
                                rx_prev_reg <= 1'b0;
                                busy_out    <= 1'b0;
                            end
                            else
                            begin
                                // Timing stays locked to this start bit
                                state_reg   <= ST_DATA;
                                bit_idx_reg <= 4'h0;
                                shift_reg   <= 10'h000;
                            end
                        end
                        // Wrap the sample count at the end of the bit
                        if (sample_reg == spb)
                        begin
                            sample_reg <= 5'h01;
                            votes_reg  <= 2'h0;
                        end
                    end
                    ST_DATA:
                    begin
                        // Sample index wraps to one at the bit end; votes clear there
                        sample_reg <= (sample_reg == spb) ? 5'h01 : sample_reg + 5'h01;
                        if (sample_reg == spb)
                        begin
                            votes_reg <= 2'h0;
                        end
                        else if (vote_win && rx_sync_reg)
                        begin
                            votes_reg <= votes_reg + 2'h1;
                        end
                        if (last_vote)
                        begin
                            if (bit_idx_reg == nbits_reg)
                            begin
                                // Stop bit voted; later stop bits never sampled
                                wr_data_reg  <= {~voted, shift_reg};
                                wr_valid_reg <= fifo_ready;
                                overrun_out  <= ~fifo_ready;
                                state_reg    <= ST_IDLE;
                                // A voted-low stop is no idle level, so a break
                                // cannot fake a start on the next low tick
                                rx_prev_reg  <= voted;
                                busy_out     <= 1'b0;
                            end
                            else
                            begin
                                // First received bit lands in bit 0
                                shift_reg[bit_idx_reg] <= voted;
                                bit_idx_reg <= bit_idx_reg + 4'h1;
                            end
                        end
                    end
                    default:
                    begin
                        // An illegal state code falls back to idle
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Disabling the receiver also empties the buffer
    always @(posedge clock_in or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            flush_reg           <= 1'b1;
            rx_pin_override_out <= 1'b0;
        end
        else
        begin
            flush_reg           <= ~receiver_enable_bit_in;
            rx_pin_override_out <= receiver_enable_bit_in;
        end
    end

    // Sixteen frames deep; a pop only passes while the head is shown
    uar_fifo #(
        .WIDTH (`UAR_FIFO_WIDTH),
        .DEPTH (`UAR_FIFO_DEPTH),
        .AW    (`UAR_FIFO_AW)
    ) u_fifo (
        .clock_in     (clock_in),
        .reset_n_in   (rst_sync_reg),
        .flush_in     (flush_reg),
        .wr_valid_in  (wr_valid_reg),
        .wr_ready_out (fifo_ready),
        .wr_data_in   (wr_data_reg),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (rd_ready_in & rd_valid_out),
        .rd_data_out  (fifo_data)
    );

    // Registered head of buffer; the output stage updates after each pop
    always @(posedge clock_in or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            rd_valid_out         <= 1'b0;
            rd_data_out          <= 10'h000;
            frame_error_flag_out <= 1'b0;
        end
        else
        begin
            rd_valid_out         <= fifo_valid & ~(rd_ready_in & rd_valid_out) & ~flush_reg;
            rd_data_out          <= fifo_data[9:0];
            frame_error_flag_out <= fifo_data[10];
        end
    end
endmodule // uar_rx

/* File: dv/uar_rx_checker.sv */
// Concurrent checks on the receive recovery block ports
module uar_rx_checker (
    input logic       clock_in,               // Clock
    input logic       reset_n_in,             // Reset, active low
    input logic       serial_rx_in,           // Line
    input logic       sample_tick_in,         // Tick
    input logic       double_speed_select_in, // Mode
    input logic       receiver_enable_bit_in, // Enable
    input logic [3:0] frame_bits_in,          // Length
    input logic       rd_ready_in,            // Pop
    input logic       rd_valid_out,           // Valid
    input logic [9:0] rd_data_out,            // Data
    input logic       frame_error_flag_out,   // Stop error
    input logic       rx_pin_override_out,    // Pin owned
    input logic       overrun_out,            // Dropped
    input logic       busy_out                // In frame
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);
    logic [7:0] tk_reg;   // Ticks since sample one
    logic [4:0] mode_reg; // Mode and length of this frame
    logic [4:0] idx;      // Bit index at end of frame
    logic [3:0] phase;    // Sample state minus one at end of frame
    logic [4:0] nlen;     // Stop-bit index for the clamped length
    ////////////////////////////////////////////////////////////////
    // Count ticks of the frame; mode is frozen once the frame starts
    always @(posedge clock_in or negedge reset_n_in)
        if (!reset_n_in)
            tk_reg <= 8'h00;
        else if (!busy_out)
            tk_reg <= 8'h00;
        else if (sample_tick_in)
            tk_reg <= tk_reg + 8'h01;
    always @(posedge clock_in)
        if (!busy_out)
            mode_reg <= {double_speed_select_in, frame_bits_in};
    // Split the count by samples per bit of the latched mode
    assign idx = mode_reg[4] ? tk_reg[7:3] : {1'b0, tk_reg[7:4]};
    assign phase = mode_reg[4] ? {1'b0, tk_reg[2:0]} : tk_reg[3:0];
    // Lengths outside 5..10 are clamped by the receiver
    assign nlen = (mode_reg[3:0] < 4'h5) ? 5'h06 : (mode_reg[3:0] > 4'hA) ? 5'h0B :
        {1'b0, mode_reg[3:0]} + 5'h01;
    ////////////////////////////////////////////////////////////////
    sequence s_end;
        $fell(busy_out) && receiver_enable_bit_in;
    endsequence
    sequence s_off;
        !receiver_enable_bit_in [*3];
    endsequence
    AST_EN_STOP: assert property ($fell(receiver_enable_bit_in) |-> ##[0:2]
        (!rx_pin_override_out && !busy_out)) else $error("enable drop not obeyed");
    AST_FLUSH: assert property (s_off |-> !rd_valid_out && !busy_out
        && !rx_pin_override_out) else $error("disabled receiver still active");
    AST_TICK_START: assert property ($rose(busy_out) |-> $past(sample_tick_in)
        || $past(sample_tick_in, 2)) else $error("start taken without tick");
    AST_IDLE_LINE: assert property (serial_rx_in [*6] |=> !$rose(busy_out))
        else $error("start taken on high line");
    AST_HOLD: assert property (rd_valid_out && !rd_ready_in && receiver_enable_bit_in
        |=> rd_valid_out && $stable(rd_data_out) && $stable(frame_error_flag_out))
        else $error("head frame changed while waiting");
    AST_POP: assert property (rd_valid_out && rd_ready_in |=> !rd_valid_out)
        else $error("valid kept after pop");
    AST_OVR: assert property (overrun_out |-> rd_valid_out ##1 !overrun_out)
        else $error("overrun not a pulse on full buffer");
    AST_PHASE: assert property (s_end |-> phase == (mode_reg[4] ? 4'h5 : 4'h9))
        else $error("frame ended off the last vote sample");
    AST_LEN: assert property (s_end |-> idx == 5'h00 || idx == nlen)
        else $error("frame length wrong");
endmodule // uar_rx_checker
bind uar_rx uar_rx_checker chk (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .serial_rx_in(serial_rx_in), .sample_tick_in(sample_tick_in),
    .double_speed_select_in(double_speed_select_in),
    .receiver_enable_bit_in(receiver_enable_bit_in), .frame_bits_in(frame_bits_in),
    .rd_ready_in(rd_ready_in), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .frame_error_flag_out(frame_error_flag_out), .rx_pin_override_out(rx_pin_override_out),
    .overrun_out(overrun_out), .busy_out(busy_out));

/* File: dv/uar_tx_model.sv */
// Behavioural remote serial transmitter driving the receive line
module uar_tx_model (
    input  logic clock_in, // System clock
    output logic line_out  // Serial line, idle high
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_out = 1'b1;
    ////////////////////////////////////////////////////////////////
    // Hold a level for some clocks; callers enter just after an edge
    task automatic hold(input logic v, input int clks);
        line_out = v;
        repeat (clks) @(posedge clock_in);
        #1;
    endtask
    // One frame, first bit first; a short stop starts the next frame early
    task automatic send(input logic [9:0] d, input int n, input logic stop,
                        input int bclk, input int sclk, input logic noise);
        hold(1'b0, bclk);
        for (int i = 0; i < n; i++)
            if (noise && i == 0)
            begin
                // One flipped sample at the bit centre, the vote must hide it
                hold(d[0], bclk / 2);
                hold(!d[0], bclk / 16);
                hold(d[0], bclk - bclk / 2 - bclk / 16);
            end
            else
                hold(d[i], bclk);
        hold(stop, sclk);
        if (!stop)
            hold(1'b1, 1);
    endtask
endmodule // uar_tx_model

/* File: dv/uart_async_rx_recovery_test.sv */
// Self-checking bench for the asynchronous receive recovery block
module uart_async_rx_recovery_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock_in, reset_n_in, tick, dss, en, rd_ready, run;
    logic [3:0] fbits;
    logic [9:0] rd_data;
    logic       line, rd_valid, fe, ovr, pin, busy;
    int         err_count, num_checks, ovr_count, tc;
    uar_rx dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .serial_rx_in(line),
        .sample_tick_in(tick), .double_speed_select_in(dss), .receiver_enable_bit_in(en),
        .frame_bits_in(fbits), .rd_ready_in(rd_ready), .rd_valid_out(rd_valid),
        .rd_data_out(rd_data), .frame_error_flag_out(fe), .rx_pin_override_out(pin),
        .overrun_out(ovr), .busy_out(busy));
    uar_tx_model tx (.clock_in(clock_in), .line_out(line));
    ////////////////////////////////////////////////////////////////
    // Clock, and a sample tick every fourth cycle once reset has settled
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial
    begin
        tick = 1'b0;
        tc = 0;
        forever
        begin
            @(posedge clock_in);
            #1;
            tick = run && (tc % 4 == 3);
            tc++;
        end
    end
    // Count dropped-frame pulses
    always @(posedge clock_in)
        if (ovr === 1'b1)
            ovr_count++;
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Wait for the head frame, judge it, then pop and let the gap cycle pass
    task automatic pop(input logic [9:0] d, input logic e);
        int k;
        k = 0;
        while (rd_valid !== 1'b1 && k < 2000)
        begin
            @(posedge clock_in);
            #1;
            k++;
        end
        check("rd_valid", {9'h000, rd_valid}, 10'h001);
        check("rd_data", rd_data, d);
        check("frame_error", {9'h000, fe}, {9'h000, e});
        rd_ready = 1'b1;
        @(posedge clock_in);
        #1;
        rd_ready = 1'b0;
        @(posedge clock_in);
        #1;
    endtask
    task automatic give_verdict();
        $display("Checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_normal();
        dss = 1'b0;
        fbits = 4'h8;
        tx.send(10'h0A5, 8, 1'b1, 65, 65, 1'b1);
        pop(10'h0A5, 1'b0);
        tx.send(10'h03C, 8, 1'b0, 64, 64, 1'b0);
        tx.hold(1'b1, 100);
        pop(10'h03C, 1'b1);
    endtask
    // Shortest and longest frames in both modes, then out-of-range lengths clamped
    task automatic t_sizes();
        logic big;
        for (int m = 0; m < 6; m++)
        begin
            dss = m[0];
            big = m[1] || m == 4;
            fbits = m[2] ? (big ? 4'hF : 4'h2) : (big ? 4'hA : 4'h5);
            tx.send(10'h2B5, big ? 10 : 5, 1'b1, m[0] ? 32 : 64, m[0] ? 32 : 64, 1'b0);
            pop(big ? 10'h2B5 : 10'h015, 1'b0);
        end
    endtask
    // Short low pulses in both modes must be thrown away
    task automatic t_glitch();
        for (int m = 0; m < 2; m++)
        begin
            dss = m[0];
            tx.hold(1'b0, m[0] ? 8 : 12);
            tx.hold(1'b1, 200);
            check("busy", {9'h000, busy}, 10'h000);
            check("rd_valid", {9'h000, rd_valid}, 10'h000);
        end
    endtask
    // Next start right after the stop vote, well before a full stop bit
    task automatic t_b2b();
        dss = 1'b0;
        fbits = 4'h8;
        tx.send(10'h081, 8, 1'b1, 64, 44, 1'b0);
        tx.send(10'h07E, 8, 1'b1, 64, 64, 1'b0);
        pop(10'h081, 1'b0);
        pop(10'h07E, 1'b0);
    endtask
    // Disable in mid-frame with a frame already buffered
    task automatic t_abort();
        tx.send(10'h055, 8, 1'b1, 64, 64, 1'b0);
        fork
            tx.send(10'h0FF, 8, 1'b1, 64, 64, 1'b0);
            begin
                repeat (300) @(posedge clock_in);
                #1;
                check("busy", {9'h000, busy}, 10'h001);
                check("rd_valid", {9'h000, rd_valid}, 10'h001);
                en = 1'b0;
                repeat (3) @(posedge clock_in);
                #1;
                check("pin", {9'h000, pin}, 10'h000);
                check("busy", {9'h000, busy}, 10'h000);
            end
        join
        en = 1'b1;
        tx.hold(1'b1, 50);
        check("rd_valid", {9'h000, rd_valid}, 10'h000);
        check("pin", {9'h000, pin}, 10'h001);
    endtask
    // Fill the buffer with the reader stalled, overflow once, then drain
    task automatic t_full();
        dss = 1'b1;
        fbits = 4'h5;
        ovr_count = 0;
        for (int i = 0; i < 17; i++)
            tx.send(i[9:0], 5, 1'b1, 32, 32, 1'b0);
        tx.hold(1'b1, 20);
        check("overrun", ovr_count[9:0], 10'h001);
        for (int i = 0; i < 16; i++)
            pop(i[9:0], 1'b0);
        check("rd_valid", {9'h000, rd_valid}, 10'h000);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        reset_n_in = 1'b0;
        en = 1'b1;
        dss = 1'b0;
        fbits = 4'h8;
        rd_ready = 1'b0;
        run = 1'b0;
        err_count = 0;
        num_checks = 0;
        ovr_count = 0;
        repeat (5) @(posedge clock_in);
        #1;
        reset_n_in = 1'b1;
        repeat (4) @(posedge clock_in);
        #1;
        run = 1'b1;
        t_normal();
        t_sizes();
        t_glitch();
        t_b2b();
        t_abort();
        t_full();
        give_verdict();
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge clock_in);
        err_count++;
        give_verdict();
    end
endmodule // uart_async_rx_recovery_test
